/* File: rtl/mif_core.sv */
/*
 Input function logic of a stepper indexer: input functions, quadrature,
 capture, move gating, power gating and current reduction, APB registers.
 Assumes an external profile generator that raises motionBusy while moving.
*/
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mif_core #(
    parameter int unsigned IDLE_CYCLES = mif_pkg::IDLE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // discrete inputs and drive sensors
    input wire logic [2:0] inRaw,
    input wire logic interlockClosed,
    input wire logic windingShort,
    input wire logic overTemp,
    // profile generator
    input wire logic motionBusy,
    output mif_pkg::mif_motion_s motion,
    // power stage
    output logic motorPowerEn,
    output logic driverEn,
    output logic [4:0] runCurrent,
    output logic [6:0] currentPct,
    output logic idleActive
);
    // =========================================================
    // declarations
    mif_pkg::mif_state_e state, next_state;
    mif_pkg::mif_incfg_s [2:0] inCfg;
    logic quadEn;
    logic [6:0] idlePct;
    logic [31:0] presetVal;
    logic [31:0] encPos;
    logic [31:0] capPos;
    logic capValid;
    logic faultShort, faultTemp, faultLoop;
    logic [1:0] runKind;
    logic runDir;
    logic busyQ;
    logic [1:0] abQ;
    logic [27:0] idleCnt;
    logic [2:0] act, rise, chg;
    logic doStart, doHard, doSoft, homeHit;

    // =========================================================
    // input conditioning
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_in
            mif_input_cond u_cond (
                .clk(clk),
                .sys_rst(sys_rst),
                .rawIn(inRaw[gi]),
                .activeLow(inCfg[gi].activeLow),
                .active(act[gi]),
                .rise(rise[gi]),
                .change(chg[gi])
            );
        end
    endgenerate

    // true if any input holding function fn shows a bit in vec;
    // inputs 1 and 2 drop out of discrete use in quadrature mode
    function automatic logic anyFn(input logic [2:0] vec, input logic [2:0] fn,
                                   input mif_pkg::mif_incfg_s [2:0] cfg, input logic quad);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (vec[i] && cfg[i].func == fn && !(quad && i < 2)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : anyFn

    // quadrature step: {step, down}; a skipped state is dropped
    function automatic logic [1:0] quadStep(input logic [1:0] prev, input logic [1:0] cur);
        logic [3:0] pair;
        pair = {prev, cur};
        case (pair)
            4'b0001, 4'b0111, 4'b1110, 4'b1000: quadStep = 2'b10;
            4'b0100, 4'b1101, 4'b1011, 4'b0010: quadStep = 2'b11;
            default: quadStep = 2'b00;
        endcase
    endfunction : quadStep

    // =========================================================
    // function decode
    wire cwAct = anyFn(act, mif_pkg::FN_CWLIM, inCfg, quadEn);
    wire ccwAct = anyFn(act, mif_pkg::FN_CCWLIM, inCfg, quadEn);
    wire estopAct = anyFn(act, mif_pkg::FN_ESTOP, inCfg, quadEn);
    wire estopRise = anyFn(rise, mif_pkg::FN_ESTOP, inCfg, quadEn);
    wire idxRise = anyFn(rise, mif_pkg::FN_INDEX, inCfg, quadEn);
    wire jogRise = anyFn(rise, mif_pkg::FN_JOGSTOP, inCfg, quadEn);
    // in quadrature mode input 3 set as home is the marker pulse
    wire homeRise = anyFn(rise, mif_pkg::FN_HOME, inCfg, quadEn);
    wire [2:0] fn3 = inCfg[2].func;

    // =========================================================
    // apb decode: zero wait states, error on unmapped offsets
    wire acc = psel & penable;
    wire wrEn = acc & pwrite;
    wire mapped = paddr == mif_pkg::REG_CTRL || paddr == mif_pkg::REG_INCFG
        || paddr == mif_pkg::REG_CURR || paddr == mif_pkg::REG_PRESET
        || paddr == mif_pkg::REG_STATUS || paddr == mif_pkg::REG_ENCPOS
        || paddr == mif_pkg::REG_CAPPOS;
    wire cmdWr = wrEn & (paddr == mif_pkg::REG_CTRL);
    wire goCmd = cmdWr & pwdata[mif_pkg::CTRL_GO];
    wire homeCmd = cmdWr & pwdata[mif_pkg::CTRL_HOME];
    wire presetCmd = cmdWr & pwdata[mif_pkg::CTRL_PRESET];
    wire faultClr = cmdWr & pwdata[mif_pkg::CTRL_FCLR];
    wire [1:0] kindCmd = pwdata[mif_pkg::CTRL_KIND_LSB +: 2];
    wire dirCmd = pwdata[mif_pkg::CTRL_DIR];
    wire [31:0] statusWord = {18'h00000, capValid, state == mif_pkg::ST_PEND,
        ccwAct, cwAct, estopAct, idleActive, faultLoop, faultTemp, faultShort,
        motorPowerEn, act, quadEn};
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = !(acc && !pwrite) ? 32'h00000000 :
        paddr == mif_pkg::REG_INCFG ? {19'h00000, quadEn, inCfg} :
        paddr == mif_pkg::REG_CURR ? {17'h00000, idlePct, 3'h0, runCurrent} :
        paddr == mif_pkg::REG_PRESET ? presetVal :
        paddr == mif_pkg::REG_STATUS ? statusWord :
        paddr == mif_pkg::REG_ENCPOS ? encPos :
        paddr == mif_pkg::REG_CAPPOS ? capPos : 32'h00000000;

    // =========================================================
    // configuration registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            inCfg <= mif_pkg::INCFG_RST;
            quadEn <= 1'b0;
            runCurrent <= mif_pkg::CURR_RUN_RST;
            idlePct <= mif_pkg::CURR_IDLE_RST;
            presetVal <= 32'h00000000;
        end else begin
            if (wrEn && paddr == mif_pkg::REG_INCFG) begin
                inCfg <= pwdata[11:0];
                quadEn <= pwdata[mif_pkg::INCFG_QUAD];
            end
            if (wrEn && paddr == mif_pkg::REG_CURR) begin
                runCurrent <= pwdata[4:0]; // one lsb per 0.2 A
                idlePct <= pwdata[mif_pkg::CURR_IDLE_LSB +: 7];
            end
            if (wrEn && paddr == mif_pkg::REG_PRESET) begin
                presetVal <= pwdata;
            end
        end
    end

    // =========================================================
    // move gating: a direction is refused while its limit is active
    wire dirOkCmd = dirCmd ? !cwAct : !ccwAct;
    wire dirOkRun = runDir ? !cwAct : !ccwAct;
    wire canStart = !estopAct && motorPowerEn;
    wire running = state == mif_pkg::ST_RUN || state == mif_pkg::ST_HOME;
    wire limitHit = running && !dirOkRun;
    wire busyFall = busyQ & ~motionBusy;
    wire jogRun = state == mif_pkg::ST_RUN && runKind == mif_pkg::KIND_JOG;

    // move state machine
    always_comb begin
        next_state = state;
        doStart = 1'b0;
        doHard = 1'b0;
        doSoft = 1'b0;
        homeHit = 1'b0;
        case (state)
            mif_pkg::ST_IDLE: begin
                if (goCmd && kindCmd == mif_pkg::KIND_INDEX) begin
                    next_state = mif_pkg::ST_PEND;
                end else if (goCmd && canStart && dirOkCmd) begin
                    doStart = 1'b1;
                    next_state = mif_pkg::ST_RUN;
                end else if (homeCmd && canStart && dirOkCmd) begin
                    doStart = 1'b1;
                    next_state = mif_pkg::ST_HOME;
                end
            end
            mif_pkg::ST_PEND: begin
                if (idxRise && canStart && dirOkRun) begin
                    doStart = 1'b1;
                    next_state = mif_pkg::ST_RUN;
                end
            end
            mif_pkg::ST_RUN: begin
                // only jog moves obey it
                doSoft = jogRun && jogRise;
                if (busyFall) begin
                    next_state = mif_pkg::ST_IDLE;
                end
            end
            mif_pkg::ST_HOME: begin
                if (homeRise) begin
                    doSoft = 1'b1;
                    homeHit = 1'b1;
                end
                if (busyFall) begin
                    next_state = mif_pkg::ST_IDLE;
                end
            end
            default: next_state = mif_pkg::ST_IDLE;
        endcase
        // immediate halt wins over start, soft stop and the next state
        if (estopRise || limitHit || (running && !motorPowerEn)) begin
            doHard = 1'b1;
            doStart = 1'b0;
            doSoft = 1'b0;
            next_state = mif_pkg::ST_IDLE;
        end
    end

    // state, move parameters and motion pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= mif_pkg::ST_IDLE;
            runKind <= mif_pkg::KIND_NORMAL;
            runDir <= 1'b0;
            busyQ <= 1'b0;
            motion <= '0;
        end else begin
            state <= next_state;
            busyQ <= motionBusy;
            if (state == mif_pkg::ST_IDLE && (goCmd || homeCmd)) begin
                runKind <= homeCmd && !goCmd ? mif_pkg::KIND_HOME : kindCmd;
                runDir <= dirCmd;
            end
            motion.start <= doStart;
            motion.kind <= state == mif_pkg::ST_IDLE ? (goCmd ? kindCmd : mif_pkg::KIND_HOME)
                : runKind;
            motion.dir <= state == mif_pkg::ST_IDLE ? dirCmd : runDir;
            motion.hardStop <= doHard;
            motion.softStop <= doSoft;
        end
    end

    // =========================================================
    // position count and capture
    wire [1:0] step = quadStep(abQ, act[1:0]);
    wire capIdx = (fn3 == mif_pkg::FN_INDEX || fn3 == mif_pkg::FN_CAPTURE) && chg[2];
    wire capJog = fn3 == mif_pkg::FN_JOGSTOP && rise[2] && jogRun;
    wire capEvt = quadEn && (capIdx || capJog);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            abQ <= 2'h0;
            encPos <= 32'h00000000;
            capPos <= 32'h00000000;
            capValid <= 1'b0;
        end else begin
            abQ <= act[1:0];
            if (presetCmd) begin
                encPos <= presetVal;
            end else if (homeHit) begin
                encPos <= 32'h00000000;
            end else if (quadEn && step[1]) begin
                encPos <= step[0] ? encPos - 32'h00000001 : encPos + 32'h00000001;
            end
            if (capEvt) begin
                capPos <= encPos;
            end
            capValid <= capEvt | (capValid & ~faultClr);
        end
    end

    // =========================================================
    // power gating and sticky faults; a new fault beats a clear
    wire powerOk = interlockClosed && !windingShort && !overTemp && !faultShort && !faultTemp;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            faultShort <= 1'b0;
            faultTemp <= 1'b0;
            faultLoop <= 1'b0;
            motorPowerEn <= 1'b0;
            driverEn <= 1'b0;
        end else begin
            faultShort <= windingShort | (faultShort & ~faultClr);
            faultTemp <= overTemp | (faultTemp & ~faultClr);
            faultLoop <= !interlockClosed | (faultLoop & ~faultClr);
            // estop does not enter here, power stays up
            motorPowerEn <= powerOk;
            driverEn <= 1'b1;
        end
    end

    // =========================================================
    // idle current reduction after a still period
    wire moving = motionBusy || running;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idleCnt <= 28'h0000000;
            idleActive <= 1'b0;
            currentPct <= mif_pkg::PCT_FULL;
        end else begin
            idleCnt <= moving ? 28'h0000000 :
                idleActive ? idleCnt : idleCnt + 28'h0000001;
            // limitation: idle level is applied only after the full wait
            idleActive <= !moving && idleCnt >= 28'(IDLE_CYCLES - 1);
            currentPct <= (!moving && idleActive) ? idlePct : mif_pkg::PCT_FULL;
        end
    end

    // =========================================================
    // assertions
    estop_halt_a: assert property (@(posedge clk) disable iff (sys_rst)
        estopRise |=> motion.hardStop && state == mif_pkg::ST_IDLE)
        else $error("estop did not halt");
    limit_halt_a: assert property (@(posedge clk) disable iff (sys_rst)
        limitHit |=> motion.hardStop && !motion.softStop)
        else $error("limit did not halt");
    limit_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
        motion.start |-> (motion.dir ? !$past(cwAct) : !$past(ccwAct)))
        else $error("move started toward active limit");
    estop_block_a: assert property (@(posedge clk) disable iff (sys_rst)
        motion.start |-> !$past(estopAct))
        else $error("move started during estop");
    estop_power_a: assert property (@(posedge clk) disable iff (sys_rst)
        estopAct && $past(powerOk) |-> motorPowerEn)
        else $error("estop removed power");
    index_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        motion.start && $past(state) == mif_pkg::ST_PEND |-> $past(idxRise))
        else $error("indexer move started without trigger");
    loop_power_a: assert property (@(posedge clk) disable iff (sys_rst)
        !interlockClosed |=> !motorPowerEn)
        else $error("power on with open interlock");
    short_power_a: assert property (@(posedge clk) disable iff (sys_rst)
        windingShort ##1 !faultClr |=> !motorPowerEn)
        else $error("power on after winding short");
    capture_pos_a: assert property (@(posedge clk) disable iff (sys_rst)
        capEvt |=> capPos == $past(encPos) && capValid)
        else $error("capture missed");
    jog_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        jogRun && jogRise && !doHard |=> motion.softStop)
        else $error("jog stop ignored");
    idle_restore_a: assert property (@(posedge clk) disable iff (sys_rst)
        motionBusy |=> !idleActive ##1 currentPct == mif_pkg::PCT_FULL)
        else $error("full current not restored");

    estop_seen_c: cover property (@(posedge clk) disable iff (sys_rst) estopRise ##1 motion.hardStop);
    index_run_c: cover property (@(posedge clk) state == mif_pkg::ST_PEND ##1 motion.start);
    home_hit_c: cover property (@(posedge clk) disable iff (sys_rst) homeHit);
    capture_c: cover property (@(posedge clk) disable iff (sys_rst) capEvt);
endmodule : mif_core
`default_nettype wire

/* File: rtl/mif_pkg.sv */
/*
 Constants, types and register map of the motion input function logic.
 Assumes a 125 MHz system clock and an APB master with 32-bit data.
*/
package mif_pkg;
    // =========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_INCFG = 8'h04;
    localparam logic [7:0] REG_CURR = 8'h08;
    localparam logic [7:0] REG_PRESET = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_ENCPOS = 8'h14;
    localparam logic [7:0] REG_CAPPOS = 8'h18;
    // =========================================================
    // command register bits
    localparam int CTRL_GO = 0;
    localparam int CTRL_KIND_LSB = 1;
    localparam int CTRL_DIR = 3;
    localparam int CTRL_HOME = 4;
    localparam int CTRL_PRESET = 5;
    localparam int CTRL_FCLR = 6;
    // input config: 4 bits per input, quadrature enable above
    localparam int INCFG_QUAD = 12;
    localparam logic [11:0] INCFG_RST = 12'h000;
    // current register fields
    localparam int CURR_IDLE_LSB = 8;
    localparam logic [4:0] CURR_RUN_RST = 5'h05;
    localparam logic [6:0] CURR_IDLE_RST = 7'h32;
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam real CURR_STEP_AMP = 0.2;
    // =========================================================
    // input functions
    localparam logic [2:0] FN_GP = 3'h0;
    localparam logic [2:0] FN_HOME = 3'h1;
    localparam logic [2:0] FN_CWLIM = 3'h2;
    localparam logic [2:0] FN_CCWLIM = 3'h3;
    localparam logic [2:0] FN_INDEX = 3'h4;
    localparam logic [2:0] FN_ESTOP = 3'h5;
    localparam logic [2:0] FN_JOGSTOP = 3'h6;
    localparam logic [2:0] FN_CAPTURE = 3'h7;
    // move kinds
    localparam logic [1:0] KIND_NORMAL = 2'h0;
    localparam logic [1:0] KIND_JOG = 2'h1;
    localparam logic [1:0] KIND_INDEX = 2'h2;
    localparam logic [1:0] KIND_HOME = 2'h3;
    // =========================================================
    // timing
    localparam int CLK_KHZ = 125000;
    localparam int IDLE_MS = 1500;
    localparam int unsigned IDLE_CYC = IDLE_MS * CLK_KHZ;
    // =========================================================
    typedef enum logic [1:0] {ST_IDLE, ST_PEND, ST_RUN, ST_HOME} mif_state_e;
    typedef struct packed {
        logic activeLow;
        logic [2:0] func;
    } mif_incfg_s;
    typedef struct packed {
        logic start;
        logic [1:0] kind;
        logic dir;
        logic hardStop;
        logic softStop;
    } mif_motion_s;
endpackage : mif_pkg

/* File: rtl/mif_input_cond.sv */
/*
 Conditioner for one discrete input: synchroniser, polarity, edges.
 Assumes the raw pin may change at any time relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mif_input_cond (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pin and polarity
    input wire logic rawIn,
    input wire logic activeLow,
    // conditioned outputs
    output logic active,
    output logic rise,
    output logic change
);
    logic syncA;
    logic syncB;
    logic level;
    logic levelQ;
    // =========================================================
    // two-stage synchroniser, then polarity
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syncA <= 1'b0;
            syncB <= 1'b0;
            level <= 1'b0;
            levelQ <= 1'b0;
        end else begin
            syncA <= rawIn;
            syncB <= syncA;
            level <= syncB ^ activeLow;
            levelQ <= level;
        end
    end
    // single-cycle events from the adjusted level
    assign active = level;
    assign rise = level & ~levelQ;
    assign change = level ^ levelQ;
endmodule : mif_input_cond
`default_nettype wire

/* File: sim/mif_field_model.sv */
/* Field model: switches and a quadrature encoder on the three pins.
   Assumes the bench calls its tasks from a clk-synchronous process. */
`timescale 1ns/1ps
`default_nettype none
module mif_field_model (
    // clock
    input wire logic clk,
    // pins toward the block
    output logic [2:0] inRaw
);
    logic [1:0] phase = 2'h0;
    initial inRaw = 3'h0;
    // ==============================
    // gray order 00,01,11,10 gives one edge per step
    task automatic step(input logic up);
        phase = up ? phase + 2'h1 : phase - 2'h1;
        @(posedge clk) inRaw[1:0] <= {phase[1], phase[1] ^ phase[0]};
        repeat (8) @(posedge clk);
    endtask : step
    // level held past the synchroniser latency
    task automatic sw(input int i, input logic lvl);
        @(posedge clk) inRaw[i] <= lvl;
        repeat (8) @(posedge clk);
    endtask : sw
endmodule : mif_field_model
`default_nettype wire

/* File: sim/tb_mif_core.sv */
/* Self-checking bench of the input function logic.
   Assumes the field model on the pins and the bench as profile generator. */
`timescale 1ns/1ps
`default_nettype none
module tb_mif_core;
    logic clk = 1'b0;
    logic sys_rst, psel, penable, pwrite, pready, pslverr;
    logic interlockClosed, windingShort, overTemp, motionBusy;
    logic motorPowerEn, driverEn, idleActive;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] inRaw;
    logic [4:0] runCurrent;
    logic [6:0] currentPct;
    mif_pkg::mif_motion_s motion;
    int err_total = 0, n_tests = 0, nStart = 0, nHard = 0, nSoft = 0;
    // rows: addr, write, wdata, expected rdata, expected pslverr
    localparam logic [73:0] ROWS [6] = '{{8'h10, 1'b0, 32'h0, 32'h10, 1'b0},
        {8'h08, 1'b0, 32'h0, 32'h3205, 1'b0},
        {8'h08, 1'b1, 32'h280a, 32'h0, 1'b0}, {8'h08, 1'b0, 32'h0, 32'h280a, 1'b0},
        {8'h00, 1'b0, 32'h0, 32'h0, 1'b0}, {8'h1c, 1'b1, 32'h1, 32'h0, 1'b1}};
    always #4 clk = ~clk;
    mif_core #(.IDLE_CYCLES(20)) i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .inRaw(inRaw),
        .interlockClosed(interlockClosed), .windingShort(windingShort),
        .overTemp(overTemp), .motionBusy(motionBusy), .motion(motion),
        .motorPowerEn(motorPowerEn), .driverEn(driverEn), .runCurrent(runCurrent),
        .currentPct(currentPct), .idleActive(idleActive));
    mif_field_model i_fld (.clk(clk), .inRaw(inRaw));
    // pulse counters, one-cycle strobes cannot be polled by tasks
    always @(posedge clk) begin
        if (motion.start === 1'b1) nStart <= nStart + 1;
        if (motion.hardStop === 1'b1) nHard <= nHard + 1;
        if (motion.softStop === 1'b1) nSoft <= nSoft + 1;
    end
    // ==============================
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        cmp("rdata", exp, r);
    endtask : rd
    // command write, then count the starts it gave
    task automatic go(input logic [31:0] c, input int dS);
        int s;
        s = nStart;
        wr(mif_pkg::REG_CTRL, c);
        repeat (3) @(posedge clk);
        cmp("starts", s + dS, nStart);
    endtask : go
    task automatic busy(input logic b);
        motionBusy <= b;
        repeat (2) @(posedge clk);
    endtask : busy
    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    // ==============================
    initial begin
        {sys_rst, psel, penable, pwrite, windingShort, overTemp, motionBusy} = 7'h40;
        {paddr, pwdata, interlockClosed} = 41'h1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        cmp("power", 1, motorPowerEn);
        foreach (ROWS[i]) begin
            logic [31:0] r;
            logic e;
            apb(ROWS[i][65], ROWS[i][73:66], ROWS[i][64:33], r, e);
            cmp("rdata", ROWS[i][32:1], r);
            cmp("pslverr", ROWS[i][0], e);
        end
        repeat (25) @(posedge clk);
        cmp("run", 32'ha, runCurrent);
        cmp("pct", 32'h28, currentPct);
        cmp("idle", 1, idleActive);
        go(32'h9, 1);
        busy(1'b1);
        cmp("pct", 32'h64, currentPct);
        cmp("idle", 0, idleActive);
        wr(mif_pkg::REG_INCFG, 32'h2);
        i_fld.sw(0, 1'b1);
        cmp("hard", 1, nHard);
        busy(1'b0);
        go(32'h9, 0);
        go(32'h1, 1);
        busy(1'b1);
        busy(1'b0);
        i_fld.sw(0, 1'b0);
        wr(mif_pkg::REG_INCFG, 32'h500);
        go(32'h9, 1);
        busy(1'b1);
        i_fld.sw(2, 1'b1);
        cmp("hard", 2, nHard);
        busy(1'b0);
        go(32'h9, 0);
        cmp("power", 1, motorPowerEn);
        cmp("driver", 1, driverEn);
        i_fld.sw(2, 1'b0);
        wr(mif_pkg::REG_INCFG, 32'h600);
        go(32'h9, 1);
        busy(1'b1);
        i_fld.sw(2, 1'b1);
        cmp("soft", 0, nSoft);
        i_fld.sw(2, 1'b0);
        busy(1'b0);
        go(32'hb, 1);
        busy(1'b1);
        i_fld.sw(2, 1'b1);
        cmp("soft", 1, nSoft);
        busy(1'b0);
        i_fld.sw(2, 1'b0);
        wr(mif_pkg::REG_INCFG, 32'h400);
        go(32'h5, 0);
        i_fld.sw(2, 1'b1);
        cmp("starts", 6, nStart);
        busy(1'b1);
        busy(1'b0);
        i_fld.sw(2, 1'b0);
        wr(mif_pkg::REG_INCFG, 32'h1400);
        wr(mif_pkg::REG_PRESET, 32'h10);
        wr(mif_pkg::REG_CTRL, 32'h20);
        rd(mif_pkg::REG_ENCPOS, 32'h10);
        repeat (4) i_fld.step(1'b1);
        i_fld.sw(2, 1'b1);
        rd(mif_pkg::REG_CAPPOS, 32'h14);
        repeat (2) i_fld.step(1'b1);
        i_fld.sw(2, 1'b0);
        rd(mif_pkg::REG_ENCPOS, 32'h16);
        rd(mif_pkg::REG_CAPPOS, 32'h16);
        wr(mif_pkg::REG_INCFG, 32'h1100);
        go(32'h10, 1);
        busy(1'b1);
        cmp("kind", mif_pkg::KIND_HOME, motion.kind);
        i_fld.sw(2, 1'b1);
        cmp("soft", 2, nSoft);
        rd(mif_pkg::REG_ENCPOS, 32'h0);
        busy(1'b0);
        i_fld.sw(2, 1'b0);
        wr(mif_pkg::REG_INCFG, 32'h1600);
        i_fld.sw(2, 1'b1);
        rd(mif_pkg::REG_CAPPOS, 32'h16);
        i_fld.sw(2, 1'b0);
        go(32'hb, 1);
        busy(1'b1);
        cmp("dir", 1, motion.dir);
        i_fld.sw(2, 1'b1);
        rd(mif_pkg::REG_CAPPOS, 32'h0);
        busy(1'b0);
        i_fld.sw(2, 1'b0);
        interlockClosed <= 1'b0;
        repeat (3) @(posedge clk);
        cmp("power", 0, motorPowerEn);
        interlockClosed <= 1'b1;
        overTemp <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("power", 0, motorPowerEn);
        overTemp <= 1'b0;
        repeat (3) @(posedge clk);
        cmp("power", 0, motorPowerEn);
        wr(mif_pkg::REG_CTRL, 32'h40);
        repeat (3) @(posedge clk);
        cmp("power", 1, motorPowerEn);
        windingShort <= 1'b1;
        @(posedge clk);
        windingShort <= 1'b0;
        repeat (3) @(posedge clk);
        cmp("power", 0, motorPowerEn);
        final_report();
    end
    // hang guard, about ten times the expected run
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        final_report();
    end
endmodule : tb_mif_core
`default_nettype wire
